// ===== design/load_store_issue_timing.sv
`timescale 1ns/10ps
// What this block does
// RULE_01 - count load time from address to writeback
// RULE_02 - stall dependent follower until load completes
// RULE_03 - independent follower overlaps the load
// RULE_04 - back-to-back loads overlap when queue allows
// RULE_05 - at most three outstanding requests queued
// RULE_06 - extra word adds cycle plus wait states
// RULE_07 - store posts address and data, no scoreboard
// RULE_08 - store after store takes two cycles
// RULE_09 - store before integer op takes three
// RULE_10 - store into full queue halts issue
// RULE_11 - decimal ops take seven or eight cycles
// RULE_12 - real move, divides fixed latencies
// RULE_13 - complex float ops vary with operands
// RULE_14 - long float ops suspend and resume
// RULE_15 - self test then fetch initialization code
// RULE_16 - software relocates control block, interrupt table; this block has no relocation logic
// RULE_17 - control block writes go to memory
// RULE_18 - requests and load data stay in order
module load_store_issue_timing
    import lsq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // issue port from decode
    input wire logic issueValid,
    input wire logic [3:0] issueOp,
    input wire logic [31:0] issueAddr,
    input wire logic [31:0] issueData,
    input wire logic [1:0] issueWords,
    input wire logic [4:0] issueDest,
    input wire logic nextUsesDest,
    input wire logic nextIsIeu,
    input wire logic zeroWait,
    input wire logic [6:0] operandExtra,
    // interrupt request pin
    input wire logic irqPin,
    // bus_control_logic side
    output logic busReqValid,
    output logic [31:0] busReqAddr,
    output logic [31:0] busReqData,
    output logic busReqWrite,
    input wire logic busReqReady,
    input wire logic busRdValid,
    input wire logic [31:0] busRdData,
    // status to pipeline
    output logic issueReady,
    output logic stall,
    output logic wbValid,
    output logic [4:0] wbDest,
    output logic [31:0] wbData,
    output logic opDone,
    output logic suspended,
    output logic fetchInit,
    output logic [1:0] outstanding
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        state_e st;
        logic [6:0] cnt;
        logic [1:0] irqSync;
        logic [1:0] loadsOut;
        logic [2:0][4:0] destFifo;
        logic [1:0] dHead;
        logic [1:0] dTail;
        logic [1:0] wordsLeft;
        logic [31:0] wordAddr;
        logic depStall;
        logic issueReady;
        logic stall;
        logic wbValid;
        logic [4:0] wbDest;
        logic [31:0] wbData;
        logic opDone;
        logic fetchInit;
        logic [1:0] outstanding;
    } core_s;

    core_s s_q;
    core_s s_d;

    logic qPush;
    logic [31:0] qAddr;
    logic [31:0] qData;
    logic qWrite;
    logic [1:0] qCount;
    logic popValidW;
    logic timerLoad;
    logic [6:0] timerValue;
    logic timerDone;
    logic [6:0] timerLeft;
    logic irqLevel;
    op_e opIn;

    function automatic logic [1:0] wrap3(input logic [1:0] p);
        wrap3 = (p == QUEUE_FULL - 2'h1) ? 2'h0 : p + 2'h1;
    endfunction

    assign opIn = op_e'(issueOp);
    assign irqLevel = s_q.irqSync[1];

    // ************************************************************
    // request queue and extension timer
    // ************************************************************
    req_queue u_queue (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pushValid(qPush),
        .pushAddr(qAddr),
        .pushData(qData),
        .pushWrite(qWrite),
        .popReady(busReqReady),
        .popValid(popValidW),
        .popAddr(busReqAddr),
        .popData(busReqData),
        .popWrite(busReqWrite),
        .count(qCount)
    );

    cycle_timer u_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .load(timerLoad),
        .loadValue(timerValue),
        .hold(irqLevel),
        .done(timerDone),
        .remaining(timerLeft)
    );

    assign busReqValid = popValidW;

    // ************************************************************
    // issue, stall and completion control
    // ************************************************************
    always_comb
    begin
        logic canQueue;
        logic accept;
        logic popLoad;
        logic roomless;
        canQueue = 1'b0;
        roomless = 1'b0;
        accept = 1'b0;
        popLoad = 1'b0;
        s_d = s_q;
        qPush = 1'b0;
        qAddr = issueAddr;
        qData = issueData;
        qWrite = 1'b0;
        timerLoad = 1'b0;
        timerValue = ONE;
        s_d.irqSync = {s_q.irqSync[0], irqPin};
        s_d.opDone = 1'b0;
        s_d.wbValid = 1'b0;
        // load data returns in issue order, writes the oldest dest
        if (busRdValid && s_q.loadsOut != 2'h0)
        begin
            popLoad = 1'b1;
            s_d.wbValid = 1'b1;   // RULE_01
            s_d.wbDest = s_q.destFifo[s_q.dHead];
            s_d.wbData = busRdData;
            s_d.dHead = wrap3(s_q.dHead);   // RULE_18
            s_d.depStall = 1'b0;   // RULE_02
        end
        // a store into a full queue freezes everything behind it
        canQueue = (qCount != QUEUE_FULL) || busReqReady;   // RULE_10
        case (s_q.st)
            ST_SELFTEST:
            begin
                s_d.cnt = s_q.cnt + ONE;
                if (s_q.cnt == SELFTEST_CYC)
                begin
                    s_d.st = ST_FETCH_INIT;   // RULE_15
                    s_d.fetchInit = 1'b1;
                    // the run state reuses cnt as its cost counter
                    s_d.cnt = 7'h00;
                end
            end
            ST_FETCH_INIT:
            begin
                s_d.st = ST_RUN;
                s_d.issueReady = 1'b1;
                s_d.fetchInit = 1'b0;   // RULE_15
            end
            ST_RUN:
            begin
                if (s_q.cnt != 7'h00)
                    s_d.cnt = s_q.cnt - ONE;
                // taken only when ready was shown, so the caller can trust it
                accept = issueValid && s_q.issueReady && s_q.cnt == 7'h00 &&
                    !s_q.depStall && s_q.wordsLeft == 2'h0;
                if (s_q.wordsLeft != 2'h0 && canQueue &&
                    ({1'b0, s_q.loadsOut} + {2'b00, !popLoad}) <=
                    {1'b0, QUEUE_FULL})
                begin
                    // each further word: one cycle plus its wait states
                    qPush = 1'b1;   // RULE_06
                    qAddr = s_q.wordAddr;
                    s_d.wordAddr = s_q.wordAddr + 32'h4;
                    s_d.wordsLeft = s_q.wordsLeft - 2'h1;
                    // every word writes back to the load's own target
                    s_d.destFifo[s_q.dTail] = s_q.destFifo[(s_q.dTail ==
                        2'h0) ? QUEUE_FULL - 2'h1 : s_q.dTail - 2'h1];
                    s_d.dTail = wrap3(s_q.dTail);   // RULE_18
                end
                else if (accept)
                begin
                    case (opIn)
                        OP_LOAD:
                        begin
                            // wait while loads outstanding reach queue depth
                            if (canQueue && (s_q.loadsOut != QUEUE_FULL ||
                                popLoad))   // RULE_05 RULE_04
                            begin
                                qPush = 1'b1;
                                s_d.destFifo[s_q.dTail] = issueDest;
                                s_d.dTail = wrap3(s_q.dTail);
                                s_d.wordsLeft = issueWords;
                                s_d.wordAddr = issueAddr + 32'h4;
                                s_d.depStall = nextUsesDest;   // RULE_02
                                // independent follower only pays issue cost
                                s_d.cnt = zeroWait ? 7'h00 : LOAD_NET_ZW;   // RULE_03
                            end
                        end
                        OP_STORE, OP_WRITE_CB:
                        begin
                            if (canQueue)
                            begin
                                qPush = 1'b1;   // RULE_07 RULE_17
                                qWrite = 1'b1;
                                s_d.cnt = (nextIsIeu ? STORE_IEU_NEXT :
                                    STORE_BASE) - ONE;   // RULE_08 RULE_09
                            end
                        end
                        OP_NONE:
                        begin
                        end
                        default:
                        begin
                            timerLoad = 1'b1;   // RULE_11 RULE_12
                            timerValue = ext_latency(opIn);
                            if (opIn == OP_SQRTL)
                                timerValue = SQRT_CYC + operandExtra;   // RULE_13
                            s_d.st = ST_BUSY;
                        end
                    endcase
                end
            end
            ST_BUSY:
            begin
                if (irqLevel)
                    s_d.st = ST_SUSPEND;   // RULE_14
                else if (timerDone)
                begin
                    s_d.opDone = 1'b1;
                    s_d.st = ST_RUN;
                end
            end
            ST_SUSPEND:
            begin
                // the timer holds its count while the handler runs
                if (!irqLevel)
                    s_d.st = ST_BUSY;   // RULE_14
            end
            default:
                s_d.st = ST_SELFTEST;
        endcase
        if (qPush && !qWrite)
            s_d.loadsOut = s_q.loadsOut + 2'h1 - (popLoad ? 2'h1 : 2'h0);
        else if (popLoad)
            s_d.loadsOut = s_q.loadsOut - 2'h1;
        if (s_q.st != ST_SELFTEST && s_q.st != ST_FETCH_INIT)
            s_d.fetchInit = 1'b0;
        // pops are ignored here: a full queue costs a cycle, never a drop
        roomless = (s_d.loadsOut == QUEUE_FULL) ||
            (({1'b0, qCount} + {2'b00, qPush}) >= {1'b0, QUEUE_FULL});
        s_d.stall = (s_d.st != ST_RUN) || s_d.depStall ||
            s_d.cnt != 7'h00 || s_d.wordsLeft != 2'h0 ||
            roomless;   // RULE_05 RULE_10
        s_d.issueReady = (s_d.st == ST_RUN) && !s_d.stall;
        s_d.outstanding = s_d.loadsOut;
    end

    // registered state
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign issueReady = s_q.issueReady;
    assign stall = s_q.stall;
    assign wbValid = s_q.wbValid;
    assign wbDest = s_q.wbDest;
    assign wbData = s_q.wbData;
    assign opDone = s_q.opDone;
    assign suspended = (s_q.st == ST_SUSPEND) && (timerLeft != 7'h00);
    assign fetchInit = s_q.fetchInit;
    assign outstanding = s_q.outstanding;

endmodule // load_store_issue_timing

// ===== design/lsq_pkg.sv
package lsq_pkg;

    // ************************************************************
    // queue and timing constants
    // ************************************************************
    localparam int QUEUE_DEPTH = 3;
    localparam logic [1:0] QUEUE_FULL = 2'h3;
    localparam logic [6:0] LOAD_BASE_ZW = 7'h04;   // dependent load, 0 ws
    localparam logic [6:0] LOAD_NET_ZW = 7'h01;    // independent load cost
    localparam logic [6:0] STORE_BASE = 7'h02;
    localparam logic [6:0] STORE_IEU_NEXT = 7'h03;
    localparam logic [6:0] DMOVT_CYC = 7'h07;
    localparam logic [6:0] DADD_CYC = 7'h08;
    localparam logic [6:0] MOVR_CYC = 7'h05;
    localparam logic [6:0] DIVR_CYC = 7'h23;
    localparam logic [6:0] DIVRL_CYC = 7'h4D;
    localparam logic [6:0] SQRT_CYC = 7'h68;
    localparam logic [6:0] SELFTEST_CYC = 7'h10;
    localparam logic [6:0] ONE = 7'h01;

    // ************************************************************
    // operation codes presented on the issue port
    // ************************************************************
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_LOAD = 4'h1,
        OP_STORE = 4'h2,
        OP_DMOVT = 4'h3,
        OP_DADDC = 4'h4,
        OP_DSUBC = 4'h5,
        OP_MOVR = 4'h6,
        OP_DIVR = 4'h7,
        OP_DIVRL = 4'h8,
        OP_SQRTL = 4'h9,
        OP_WRITE_CB = 4'hA
    } op_e;

    typedef enum logic [2:0] {
        ST_SELFTEST = 3'h0,
        ST_FETCH_INIT = 3'h1,
        ST_RUN = 3'h2,
        ST_BUSY = 3'h3,
        ST_SUSPEND = 3'h4
    } state_e;

    // signed-free latency lookup for the extension unit
    function automatic logic [6:0] ext_latency(input op_e op);
        case (op)
            OP_DMOVT: ext_latency = DMOVT_CYC;
            OP_DADDC: ext_latency = DADD_CYC;
            OP_DSUBC: ext_latency = DADD_CYC;
            OP_MOVR: ext_latency = MOVR_CYC;
            OP_DIVR: ext_latency = DIVR_CYC;
            OP_DIVRL: ext_latency = DIVRL_CYC;
            OP_SQRTL: ext_latency = SQRT_CYC;
            default: ext_latency = ONE;
        endcase
    endfunction

endpackage

// ===== design/req_queue.sv
`timescale 1ns/10ps
// in-order three-entry request queue toward bus_control_logic
module req_queue
    import lsq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // push side
    input wire logic pushValid,
    input wire logic [31:0] pushAddr,
    input wire logic [31:0] pushData,
    input wire logic pushWrite,
    // pop side
    input wire logic popReady,
    output logic popValid,
    output logic [31:0] popAddr,
    output logic [31:0] popData,
    output logic popWrite,
    output logic [1:0] count
);

    typedef struct packed {
        logic [2:0][64:0] mem;
        logic [1:0] wrPtr;
        logic [1:0] rdPtr;
        logic [1:0] cnt;
    } qstate_s;

    qstate_s q_q;
    qstate_s q_d;
    logic doPush;
    logic doPop;

    function automatic logic [1:0] bump(input logic [1:0] p);
        bump = (p == QUEUE_FULL - 2'h1) ? 2'h0 : p + 2'h1;
    endfunction

    // next state: push when not full, pop oldest first
    always_comb
    begin
        q_d = q_q;
        doPop = popReady && (q_q.cnt != 2'h0);
        doPush = pushValid && (q_q.cnt != QUEUE_FULL);   // RULE_05
        if (doPush)
        begin
            q_d.mem[q_q.wrPtr] = {pushWrite, pushAddr, pushData};
            q_d.wrPtr = bump(q_q.wrPtr);
        end
        if (doPop)
            q_d.rdPtr = bump(q_q.rdPtr);   // RULE_18
        case ({doPush, doPop})
            2'b10: q_d.cnt = q_q.cnt + 2'h1;
            2'b01: q_d.cnt = q_q.cnt - 2'h1;
            default: q_d.cnt = q_q.cnt;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            q_q <= '0;
        else
            q_q <= q_d;
    end

    assign popValid = (q_q.cnt != 2'h0);
    assign popWrite = q_q.mem[q_q.rdPtr][64];
    assign popAddr = q_q.mem[q_q.rdPtr][63:32];
    assign popData = q_q.mem[q_q.rdPtr][31:0];
    assign count = q_q.cnt;

endmodule // req_queue

// ===== design/cycle_timer.sv
`timescale 1ns/10ps
// down-counter that can freeze, used for extension-unit latencies
module cycle_timer
    import lsq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // control
    input wire logic load,
    input wire logic [6:0] loadValue,
    input wire logic hold,
    // status
    output logic done,
    output logic [6:0] remaining
);

    typedef struct packed {
        logic [6:0] cnt;
    } tstate_s;

    tstate_s t_q;
    tstate_s t_d;

    // hold keeps the remaining count so a suspended op resumes in place
    always_comb
    begin
        t_d = t_q;
        if (load)
            t_d.cnt = loadValue;
        else if (!hold && t_q.cnt != 7'h00)
            t_d.cnt = t_q.cnt - ONE;   // RULE_14
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            t_q <= '0;
        else
            t_q <= t_d;
    end

    assign done = (t_q.cnt == ONE) && !hold && !load;
    assign remaining = t_q.cnt;

endmodule // cycle_timer

// ===== sim/lsq_mem_model.sv
`timescale 1ns/10ps
// far-side memory behind bus_control_logic, one request at a time
module lsq_mem_model
    import lsq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // request from the block
    input wire logic busReqValid,
    input wire logic [31:0] busReqAddr,
    input wire logic busReqWrite,
    output logic busReqReady,
    // read return
    output logic busRdValid,
    output logic [31:0] busRdData,
    // bench control
    input wire logic holdOff,
    input wire logic [3:0] waitCyc
);
    logic [3:0] waitQ;

    // takes the head after the wait states; holdOff lets the queue fill
    assign busReqReady = busReqValid && !holdOff && waitQ == waitCyc;

    // read data next edge; idle data toggles so stale values never match
    always_ff @(posedge ref_clk)
    begin
        if (busReqValid && !busReqReady && !holdOff)
            waitQ <= waitQ + 4'h1;
        else
            waitQ <= 4'h0;
        busRdValid <= nrst && busReqReady && !busReqWrite;
        if (!nrst)
            busRdData <= 32'h00000000;
        else if (busReqReady && !busReqWrite)
            busRdData <= busReqAddr ^ 32'h5A5A0000;
        else
            busRdData <= ~busRdData;
    end
endmodule // lsq_mem_model

// ===== sim/load_store_issue_timing_assertions.sv
`timescale 1ns/10ps
module load_store_issue_timing_assertions
    import lsq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // issue side
    input wire logic issueValid,
    input wire logic [3:0] issueOp,
    input wire logic issueReady,
    input wire logic stall,
    // bus side
    input wire logic busReqValid,
    input wire logic [31:0] busReqAddr,
    input wire logic busReqWrite,
    input wire logic busReqReady,
    input wire logic busRdValid,
    // status
    input wire logic wbValid,
    input wire logic opDone,
    input wire logic suspended,
    input wire logic fetchInit,
    input wire logic [1:0] outstanding
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_quiet;
        !fetchInit && !issueReady;
    endsequence
    sequence s_upSoon;
        ##[1:4] issueReady;
    endsequence

    property p_wbAfterRd; busRdValid |=> wbValid; endproperty
    a_wbAfterRd: assert property (p_wbAfterRd) else $error("no writeback");
    property p_wbCause; wbValid |-> $past(busRdValid); endproperty
    a_wbCause: assert property (p_wbCause) else $error("stray writeback");
    property p_bootQuiet; $rose(nrst) |-> s_quiet [*8]; endproperty
    a_bootQuiet: assert property (p_bootQuiet) else $error("early start");
    property p_bootReady; fetchInit |-> s_upSoon; endproperty
    a_bootReady: assert property (p_bootReady) else $error("no issue");
    property p_fetchPulse; fetchInit |=> !fetchInit [*4]; endproperty
    a_fetchPulse: assert property (p_fetchPulse) else $error("fetch again");
    property p_headHold;
        busReqValid && !busReqReady |=>
            busReqValid && $stable(busReqAddr) && $stable(busReqWrite);
    endproperty
    a_headHold: assert property (p_headHold) else $error("head moved");
    property p_fullStall;
        outstanding == QUEUE_FULL && issueValid && issueOp == OP_LOAD |-> stall;
    endproperty
    a_fullStall: assert property (p_fullStall) else $error("no stall");
    property p_donePulse; opDone |=> !opDone; endproperty
    a_donePulse: assert property (p_donePulse) else $error("long done");
    property p_suspQuiet; suspended |-> !opDone; endproperty
    a_suspQuiet: assert property (p_suspQuiet) else $error("done held");
endmodule // load_store_issue_timing_assertions

bind load_store_issue_timing load_store_issue_timing_assertions chk_u (
    .ref_clk, .nrst, .issueValid, .issueOp, .issueReady, .stall,
    .busReqValid, .busReqAddr, .busReqWrite, .busReqReady, .busRdValid,
    .wbValid, .opDone, .suspended, .fetchInit, .outstanding
);

// ===== sim/load_store_issue_timing_tb.sv
`timescale 1ns/10ps
module load_store_issue_timing_tb
    import lsq_pkg::*;
;
    logic ref_clk, nrst, issueValid, nextUsesDest, nextIsIeu, zeroWait;
    logic irqPin, holdOff, busReqValid, busReqWrite, busReqReady;
    logic busRdValid, issueReady, stall, wbValid, opDone, suspended;
    logic fetchInit;
    logic [3:0] issueOp, waitCyc;
    logic [31:0] issueAddr, issueData, busReqAddr, busReqData;
    logic [31:0] busRdData, wbData;
    logic [4:0] issueDest, wbDest;
    logic [6:0] operandExtra;
    logic [1:0] issueWords, outstanding;
    logic [31:0] aQ[$];
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    int takeAt, n;

    // ************************************************************
    // clock, block, far side
    // ************************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    load_store_issue_timing dut_u (
        .ref_clk, .nrst, .issueValid, .issueOp, .issueAddr, .issueData,
        .issueWords, .issueDest, .nextUsesDest, .nextIsIeu, .zeroWait,
        .operandExtra, .irqPin, .busReqValid, .busReqAddr, .busReqData,
        .busReqWrite, .busReqReady, .busRdValid, .busRdData, .issueReady,
        .stall, .wbValid, .wbDest, .wbData, .opDone, .suspended,
        .fetchInit, .outstanding
    );

    lsq_mem_model mem_u (
        .ref_clk, .nrst, .busReqValid, .busReqAddr, .busReqWrite,
        .busReqReady, .busRdValid, .busRdData, .holdOff, .waitCyc
    );

    // requests as they leave, so order can be judged later
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (busReqValid && busReqReady)
            aQ.push_back(busReqAddr);
        if (busReqValid && busReqReady && busReqWrite)
            check(busReqData, ~busReqAddr, "storeData");
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // offer an op, holding it until ready and not stalled
    task automatic issue(input op_e op, input logic [31:0] a,
        input logic [1:0] w, input int hold);
        @(posedge ref_clk);
        issueValid <= 1'b1;
        issueOp <= op;
        issueAddr <= a;
        issueData <= ~a;
        issueWords <= w;
        repeat (hold) @(negedge ref_clk);
        do
            @(posedge ref_clk);
        while (!issueReady);
        issueValid <= 1'b0;
        takeAt = cyc;
    endtask

    // edges from take to opDone; irqPin high for ten of them
    task automatic waitDone(input int irqAt, output int k);
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
            irqPin <= (k >= irqAt && k < irqAt + 10);
            @(negedge ref_clk);
            if (k == irqAt + 6)
                check(32'(suspended), 32'h1, "suspended");
        end
        while (!opDone && k < 400);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_load(input logic dep, input logic [3:0] ws,
        input logic [1:0] w);
        int k;
        logic [31:0] a;
        a = 32'h00001000 + 32'(ws) * 32'h10;
        @(posedge ref_clk);
        waitCyc <= ws;
        zeroWait <= (ws == 4'h0);
        nextUsesDest <= dep;
        aQ.delete();
        issue(OP_LOAD, a, w, 0);
        @(negedge ref_clk);
        check(32'(stall), 32'(dep || ws != 0 || w != 0), "stall");
        k = 1;
        while (!wbValid && k < 60)
        begin
            @(negedge ref_clk);
            k++;
        end
        check(32'(k <= 4 + ws), 32'h1, "loadTime");
        check(wbData, a ^ 32'h5A5A0000, "wbData");
        check(32'(wbDest), 32'h0000000A, "wbDest");
        repeat (20) @(negedge ref_clk);
        check(32'(outstanding), 32'h0, "drained");
        check(32'(aQ.size()), 32'(w) + 1, "words");
        check(aQ[aQ.size() - 1], a + 32'(w) * 4, "lastAddr");
    endtask

    // three stores fill the queue, a fourth is held back
    task automatic t_stores;
        int t0;
        aQ.delete();
        holdOff <= 1'b1;
        issue(OP_STORE, 32'h00002000, 2'h0, 0);
        t0 = takeAt;
        nextIsIeu <= 1'b1;
        issue(OP_STORE, 32'h00002004, 2'h0, 0);
        check(32'(takeAt - t0), 32'h2, "storeGap");
        t0 = takeAt;
        nextIsIeu <= 1'b0;
        issue(OP_STORE, 32'h00002008, 2'h0, 0);
        check(32'(takeAt - t0), 32'h3, "ieuGap");
        fork
            issue(OP_WRITE_CB, 32'h0000200C, 2'h0, 8);
            begin
                repeat (6) @(negedge ref_clk);
                check(32'(stall), 32'h1, "fullStall");
                check(32'(aQ.size()), 32'h0, "held");
                @(posedge ref_clk);
                holdOff <= 1'b0;
            end
        join
        repeat (20) @(negedge ref_clk);
        check(32'(aQ.size()), 32'h4, "stores");
        for (int i = 0; i < 4; i++)
            check(aQ[i], 32'h00002000 + 32'(i) * 4, "order");
    endtask

    task automatic t_ext;
        op_e ops[7] = '{OP_DMOVT, OP_DADDC, OP_DSUBC, OP_MOVR, OP_DIVR,
            OP_DIVRL, OP_SQRTL};
        int lat[7] = '{7, 8, 8, 5, 35, 77, 107};
        int k;
        foreach (ops[i])
        begin
            issue(ops[i], 32'h00000000, 2'h0, 0);
            waitDone(999, k);
            check(32'(k), 32'(lat[i]), "latency");
        end
        issue(OP_DIVR, 32'h00000000, 2'h0, 0);
        waitDone(5, k);
        check(32'(k), 32'h0000002D, "resumed");
    endtask

    // main sequence
    initial
    begin
        nrst = 1'b0;
        issueValid = 1'b0;
        issueOp = 4'h0;
        issueAddr = 32'h00000000;
        issueData = 32'h00000000;
        issueWords = 2'h0;
        issueDest = 5'h0A;
        nextUsesDest = 1'b0;
        nextIsIeu = 1'b0;
        zeroWait = 1'b1;
        operandExtra = 7'h03;
        irqPin = 1'b0;
        holdOff = 1'b0;
        waitCyc = 4'h0;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        n = 0;
        while (!fetchInit && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        check(32'(n >= 16), 32'h1, "selfTest");
        t_load(1'b1, 4'h0, 2'h0);
        t_load(1'b1, 4'h2, 2'h0);
        t_load(1'b0, 4'h0, 2'h0);
        t_load(1'b0, 4'h1, 2'h1);
        t_stores;
        t_ext;
        give_verdict;
    end

    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        give_verdict;
    end
endmodule // load_store_issue_timing_tb
